/* File: rtl/dcta_hyst_cmp.sv */
`timescale 1ns/10ps
module dcta_hyst_cmp
   import dcta_pkg::*;
(
   input  logic       clock,
   input  logic       rst_n,
   input  logic       update,
   input  dcta_temp_t reading,
   input  dcta_temp_t limit,
   input  logic       mode_lt,
   output logic       state_q
);

   logic state_d;

   // Trip and release thresholds one degree apart
   wire set_gt = reading > limit; // R10
   wire clr_gt = reading <= limit - HYST_DEG; // R10
   wire set_lt = reading < limit; // R11
   wire clr_lt = reading >= limit + HYST_DEG; // R11
   wire set_c  = mode_lt ? set_lt : set_gt;
   wire clr_c  = mode_lt ? clr_lt : clr_gt;

   // State moves only on a fresh reading, so it holds between samples
   assign state_d = !update ? state_q : (state_q ? !clr_c : set_c);

   // Hysteresis state starts false
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= 1'b0;
      else
         state_q <= state_d;
   end

   chk_gt_trip: assert property (@(posedge clock) disable iff (!rst_n) // R10
      update && !mode_lt && !state_q && reading > limit |=> state_q)
      else $error("greater-than compare did not trip");

   chk_hyst_hold: assert property (@(posedge clock) disable iff (!rst_n) // R11
      update && state_q && mode_lt && reading < limit + HYST_DEG
      |=> state_q)
      else $error("less-than compare released inside hysteresis");

   chk_idle_hold: assert property (@(posedge clock) disable iff (!rst_n) // R1
      !update |=> state_q == $past(state_q))
      else $error("compare state moved without a reading");

endmodule

/* File: rtl/dcta_pkg.sv */
package dcta_pkg;

   // Temperature words are signed whole degrees
   localparam int                TEMP_W      = 10;
   typedef logic signed [TEMP_W-1:0] dcta_temp_t;
   localparam int                NUM_CH      = 2;
   localparam dcta_temp_t        HYST_DEG    = 10'sh001;
   localparam int                SP_STEP_SH  = 2;
   localparam dcta_temp_t        SP_BIAS_DEG = 10'sh001;
   localparam int                CRITICAL_COMPARE_W      = 8;
   localparam int                OFS_W       = 6;

   // Timing of the channel switch before each conversion
   localparam int                CLK_PERIOD_NS = 4;
   localparam int                SETTLE_NS     = 100;
   localparam int                SETTLE_CYC    =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int                CNT_W         = 8;
   localparam logic [CNT_W-1:0]  SETTLE_LAST   = CNT_W'(SETTLE_CYC - 1);

   // Register map
   localparam int                ADDR_W       = 8;
   localparam int                DATA_W       = 32;
   localparam logic [ADDR_W-1:0] REG_CONFIG   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_LIMITS   = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_READING0 = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_READING1 = 8'h10;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h18;

   // Field positions and reset values
   localparam int                CFG_EN_BIT      = 0;
   localparam int                CFG_CRITICAL_COMPARE_LT_BIT = 1;
   localparam int                CFG_L0_LT_BIT   = 2;
   localparam int                CFG_L1_LT_BIT   = 3;
   localparam logic [DATA_W-1:0] CFG_MASK        = 32'h0000_000F;
   localparam logic [DATA_W-1:0] CFG_RESET       = 32'h0000_0001;
   localparam int                LIM_CRITICAL_COMPARE_LSB    = 0;
   localparam int                LIM_A_LSB       = 8;
   localparam int                LIM_B_LSB       = 16;
   localparam logic [DATA_W-1:0] LIM_MASK        = 32'h003F_3FFF;
   localparam logic [DATA_W-1:0] LIM_RESET       = 32'h0000_0064;
   localparam int                ST_ALARM_LSB    = 0;
   localparam int                ST_VALID_LSB    = 3;
   localparam int                ST_CAUSE_LSB    = 5;
   localparam int                ST_PIN_LSB      = 8;
   localparam int                NUM_ALARM       = 3;
   localparam int                AL_CRITICAL_COMPARE         = 0;
   localparam int                AL_L0           = 1;
   localparam int                AL_L1           = 2;
   localparam int                IRQ_W           = 4;
   localparam int                IRQ_SCAN        = 3;

endpackage

/* File: rtl/dcta_scan.sv */
`timescale 1ns/10ps
module dcta_scan
   import dcta_pkg::*;
(
   input  logic              clock,
   input  logic              rst_n,
   input  logic              enable,
   input  logic              conv_done,
   input  dcta_temp_t        conv_temp,
   output logic              conv_start_q,
   output logic              conv_channel_q,
   output logic [NUM_CH-1:0] upd_q,
   output logic [NUM_CH-1:0] valid_q,
   output dcta_temp_t        reading0,
   output dcta_temp_t        reading1
);

   typedef enum logic [1:0] {SC_IDLE, SC_SETTLE, SC_CONV} dcta_scan_t;

   dcta_scan_t        state_q, state_d;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic              start_d;
   dcta_temp_t        rd_q [NUM_CH];

   wire conv_end = (state_q == SC_CONV) && conv_done;

   // One channel at a time: the next settle starts only after done
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      start_d = 1'b0;
      case (state_q)
         SC_IDLE:
            if (enable)
            begin
               state_d = SC_SETTLE;
               cnt_d   = '0;
            end
         SC_SETTLE:
            if (cnt_q == SETTLE_LAST)
            begin
               state_d = SC_CONV;
               start_d = 1'b1;
            end
            else
               cnt_d = cnt_q + 1'b1;
         SC_CONV:
            if (conv_done)
            begin
               state_d = enable ? SC_SETTLE : SC_IDLE;
               cnt_d   = '0;
            end
         default:
            state_d = SC_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q        <= SC_IDLE;
         cnt_q          <= '0;
         conv_start_q   <= 1'b0;
         conv_channel_q <= 1'b0;
      end
      else
      begin
         state_q        <= state_d;
         cnt_q          <= cnt_d;
         conv_start_q   <= start_d; // R1
         conv_channel_q <= conv_channel_q ^ conv_end; // R1
      end
   end

   // Each channel keeps its own latest reading and valid flag
   for (genvar ch = 0; ch < NUM_CH; ch++)
   begin : g_ch
      wire hit = conv_end && (conv_channel_q == 1'(ch));
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            rd_q[ch]    <= '0;
            valid_q[ch] <= 1'b0;
            upd_q[ch]   <= 1'b0;
         end
         else
         begin
            rd_q[ch]    <= hit ? conv_temp : rd_q[ch]; // R1
            valid_q[ch] <= valid_q[ch] | hit;
            upd_q[ch]   <= hit;
         end
      end
   end

   assign reading0 = rd_q[0];
   assign reading1 = rd_q[1];

   chk_start_conv: assert property (@(posedge clock) disable iff (!rst_n) // R1
      conv_start_q |-> state_q == SC_CONV)
      else $error("conversion started outside the convert state");

   chk_chan_turn: assert property (@(posedge clock) disable iff (!rst_n) // R1
      conv_end |=> conv_channel_q != $past(conv_channel_q))
      else $error("channel did not alternate after a conversion");

endmodule

/* File: rtl/dcta_top.sv */
// What this block does
// R1 - Channels convert one after another; each updates from its own reading.
// R2 - Alarm pins are open-drain: pulled low when asserted, else released.
// R3 - Critical alarm asserts when either channel trips the shared limit.
// R4 - Critical alarm releases when the causing channel clears by a degree.
// R5 - One greater/less choice covers both channels' critical compares.
// R6 - Limit-one alarm follows channel one against its limit, with hysteresis.
// R7 - Limit-one compare has its own greater/less choice.
// R8 - Limit-zero alarm tracks its channel against its limit, with hysteresis.
// R9 - Limit-zero compare has its own greater/less choice.
// R10 - Greater mode trips above limit, clears at or below limit minus one.
// R11 - Less mode trips below limit, clears at or above limit plus one.
// R12 - Each setpoint is critical limit plus four times offset plus one.
// R13 - After reset alarms stay released until both channels have read once.
// R14 - Separate state per compare and channel; the setter decides release.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module dcta_top
   import dcta_pkg::*;
(
   input  logic              clock,
   input  logic              rst_n,
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic              pready,
   output logic              pslverr,
   output logic              conv_start,
   output logic              conv_channel,
   input  logic              conv_done,
   input  dcta_temp_t        conv_temp,
   input  logic              critical_alarm_n_i,
   output logic              critical_alarm_n_o,
   output logic              critical_alarm_n_oe,
   input  logic              limit0_alarm_n_i,
   output logic              limit0_alarm_n_o,
   output logic              limit0_alarm_n_oe,
   input  logic              limit1_alarm_n_i,
   output logic              limit1_alarm_n_o,
   output logic              limit1_alarm_n_oe,
   output logic              irq
);

   logic [DATA_W-1:0]    cfg_q;
   logic [DATA_W-1:0]    lim_q;
   logic [IRQ_W-1:0]     irq_stat_q, irq_stat_d;
   logic [IRQ_W-1:0]     irq_mask_q;
   logic                 irq_q;
   logic [DATA_W-1:0]    prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic [NUM_ALARM-1:0] alarm_oe_q;
   logic [NUM_ALARM-1:0] pull_level_q;
   logic [NUM_ALARM-1:0] pin_meta_q;
   logic [NUM_ALARM-1:0] pin_sync_q;
   logic [NUM_CH-1:0]    upd;
   logic [NUM_CH-1:0]    valid;
   logic [NUM_CH-1:0]    critical_compare_st;
   logic                 l0_st;
   logic                 l1_st;
   dcta_temp_t           reading0;
   dcta_temp_t           reading1;
   dcta_temp_t           rd_arr [NUM_CH];

   // Sequential sampling of the two sensing channels
   dcta_scan u_scan
   (
      .clock          (clock),
      .rst_n          (rst_n),
      .enable         (cfg_q[CFG_EN_BIT]),
      .conv_done      (conv_done),
      .conv_temp      (conv_temp),
      .conv_start_q   (conv_start),
      .conv_channel_q (conv_channel),
      .upd_q          (upd),
      .valid_q        (valid),
      .reading0       (reading0),
      .reading1       (reading1)
   );

   assign rd_arr[0] = reading0;
   assign rd_arr[1] = reading1;

   // Limits: offsets are signed steps of four degrees around the critical
   wire [CRITICAL_COMPARE_W-1:0] critical_compare_raw = lim_q[LIM_CRITICAL_COMPARE_LSB +: CRITICAL_COMPARE_W];
   wire [OFS_W-1:0]  ofs_a    = lim_q[LIM_A_LSB +: OFS_W];
   wire [OFS_W-1:0]  ofs_b    = lim_q[LIM_B_LSB +: OFS_W];
   wire dcta_temp_t  critical_limit = dcta_temp_t'({2'b00, critical_compare_raw});
   wire dcta_temp_t  ofs_a_ext =
      dcta_temp_t'({{(TEMP_W-OFS_W){ofs_a[OFS_W-1]}}, ofs_a});
   wire dcta_temp_t  ofs_b_ext =
      dcta_temp_t'({{(TEMP_W-OFS_W){ofs_b[OFS_W-1]}}, ofs_b});
   wire dcta_temp_t  limit0_value =
      critical_limit + (ofs_a_ext <<< SP_STEP_SH) + SP_BIAS_DEG; // R12
   wire dcta_temp_t  limit1_value =
      critical_limit + (ofs_b_ext <<< SP_STEP_SH) + SP_BIAS_DEG; // R12

   // Critical compare per channel; one mode bit serves both
   for (genvar ch = 0; ch < NUM_CH; ch++)
   begin : g_critical_compare
      dcta_hyst_cmp u_critical_compare_cmp
      (
         .clock   (clock),
         .rst_n   (rst_n),
         .update  (upd[ch]),
         .reading (rd_arr[ch]),
         .limit   (critical_limit),
         .mode_lt (cfg_q[CFG_CRITICAL_COMPARE_LT_BIT]), // R5
         .state_q (critical_compare_st[ch]) // R14
      );
   end

   // Limit-zero compare watches channel zero
   dcta_hyst_cmp u_l0_cmp
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .update  (upd[0]),
      .reading (reading0),
      .limit   (limit0_value),
      .mode_lt (cfg_q[CFG_L0_LT_BIT]), // R9
      .state_q (l0_st) // R8
   );

   // Limit-one compare watches channel one
   dcta_hyst_cmp u_l1_cmp
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .update  (upd[1]),
      .reading (reading1),
      .limit   (limit1_value),
      .mode_lt (cfg_q[CFG_L1_LT_BIT]), // R7
      .state_q (l1_st) // R6
   );

   // Alarms stay released until both channels have a reading
   wire all_valid = &valid; // R13
   wire critical_compare_on   = all_valid && (|critical_compare_st); // R3 R4
   wire [NUM_ALARM-1:0] alarm_on = {all_valid && l1_st,
                                    all_valid && l0_st,
                                    critical_compare_on};
   wire [NUM_ALARM-1:0] alarm_rise = alarm_on & ~alarm_oe_q;

   // Open-drain drive: the output level is always low, only enable moves
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_oe_q   <= '0;
         pull_level_q <= '0;
      end
      else
      begin
         alarm_oe_q   <= alarm_on; // R2
         pull_level_q <= '0; // R2
      end
   end

   assign critical_alarm_n_oe = alarm_oe_q[AL_CRITICAL_COMPARE];
   assign limit0_alarm_n_oe   = alarm_oe_q[AL_L0];
   assign limit1_alarm_n_oe   = alarm_oe_q[AL_L1];
   assign critical_alarm_n_o  = pull_level_q[AL_CRITICAL_COMPARE];
   assign limit0_alarm_n_o    = pull_level_q[AL_L0];
   assign limit1_alarm_n_o    = pull_level_q[AL_L1];

   // Pin levels come back through two flops; another driver shows here
   wire [NUM_ALARM-1:0] pin_raw = {limit1_alarm_n_i,
                                   limit0_alarm_n_i,
                                   critical_alarm_n_i};
   for (genvar p = 0; p < NUM_ALARM; p++)
   begin : g_pin
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            pin_meta_q[p] <= 1'b1;
            pin_sync_q[p] <= 1'b1;
         end
         else
         begin
            pin_meta_q[p] <= pin_raw[p];
            pin_sync_q[p] <= pin_meta_q[p];
         end
      end
   end

   // APB decode: one wait state so read data leaves a flop
   wire access   = psel && penable;
   wire xfer_end = access && pready_q;
   wire wr_en    = xfer_end && pwrite;
   wire hit_cfg  = paddr == REG_CONFIG;
   wire hit_lim  = paddr == REG_LIMITS;
   wire hit_stat = paddr == REG_STATUS;
   wire hit_rd0  = paddr == REG_READING0;
   wire hit_rd1  = paddr == REG_READING1;
   wire hit_ist  = paddr == REG_IRQ_STAT;
   wire hit_imk  = paddr == REG_IRQ_MASK;
   wire hit_any  = hit_cfg | hit_lim | hit_stat | hit_rd0 | hit_rd1 |
                   hit_ist | hit_imk;

   // Status word shows alarm drive, valid flags, cause and pin levels
   wire [DATA_W-1:0] stat_word =
      (DATA_W'(alarm_oe_q) << ST_ALARM_LSB) |
      (DATA_W'(valid)      << ST_VALID_LSB) |
      (DATA_W'(critical_compare_st)    << ST_CAUSE_LSB) |
      (DATA_W'(pin_sync_q) << ST_PIN_LSB);
   wire [DATA_W-1:0] rd0_word =
      {{(DATA_W-TEMP_W){reading0[TEMP_W-1]}}, reading0};
   wire [DATA_W-1:0] rd1_word =
      {{(DATA_W-TEMP_W){reading1[TEMP_W-1]}}, reading1};
   wire [DATA_W-1:0] rd_sel =
      hit_cfg  ? cfg_q :
      hit_lim  ? lim_q :
      hit_stat ? stat_word :
      hit_rd0  ? rd0_word :
      hit_rd1  ? rd1_word :
      hit_ist  ? DATA_W'(irq_stat_q) :
      hit_imk  ? DATA_W'(irq_mask_q) :
      '0;

   // Bus answer registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= access && !pready_q;
         prdata_q  <= (access && !pready_q && !pwrite) ? rd_sel : '0;
         pslverr_q <= access && !pready_q && !hit_any;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Configuration registers; unmapped bits stay zero
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q      <= CFG_RESET;
         lim_q      <= LIM_RESET;
         irq_mask_q <= '0;
      end
      else
      begin
         if (wr_en && hit_cfg)
            cfg_q <= pwdata & CFG_MASK;
         if (wr_en && hit_lim)
            lim_q <= pwdata & LIM_MASK;
         if (wr_en && hit_imk)
            irq_mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // Sticky events: an event in the clearing cycle survives the clear
   wire [IRQ_W-1:0] irq_evt = {upd[1], alarm_rise};
   wire [IRQ_W-1:0] irq_clr =
      (wr_en && hit_ist) ? pwdata[IRQ_W-1:0] : '0;
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign irq = irq_q;

   chk_critical_compare_assert: assert property (@(posedge clock) // R3
      disable iff (!rst_n)
      all_valid && (|critical_compare_st) |=> critical_alarm_n_oe)
      else $error("critical alarm not pulled while a channel trips");

   chk_startup_quiet: assert property (@(posedge clock) // R13
      disable iff (!rst_n)
      !all_valid |=> !(critical_alarm_n_oe || limit0_alarm_n_oe ||
                       limit1_alarm_n_oe))
      else $error("alarm driven before both channels were read");

   chk_never_high: assert property (@(posedge clock) disable iff (!rst_n) // R2
      !critical_alarm_n_o && !limit0_alarm_n_o && !limit1_alarm_n_o)
      else $error("alarm pin driven high");

   chk_limit_follow: assert property (@(posedge clock) // R8
      disable iff (!rst_n)
      all_valid && $changed(l0_st) |=> limit0_alarm_n_oe == $past(l0_st))
      else $error("limit-zero alarm does not follow its compare");

   chk_irq_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      irq_evt[AL_CRITICAL_COMPARE] |=> irq_stat_q[AL_CRITICAL_COMPARE] ##1 irq_stat_q[AL_CRITICAL_COMPARE] ||
                           $past(wr_en && hit_ist))
      else $error("critical event lost from status");

   // Alarm pins and event flags follow their compares; the irq line follows unmasked flags
   chk_l1_follow: assert property (@(posedge clock) // R6
      disable iff (!rst_n)
      all_valid && $changed(l1_st) |=> limit1_alarm_n_oe == $past(l1_st))
      else $error("limit-one alarm does not follow its compare");

   chk_critical_compare_release: assert property (@(posedge clock) // R4
      disable iff (!rst_n)
      !(|critical_compare_st) |=> !critical_alarm_n_oe)
      else $error("critical alarm held with no channel tripped");

   chk_l1_event: assert property (@(posedge clock)
      disable iff (!rst_n)
      alarm_rise[AL_L1] |=> irq_stat_q[AL_L1])
      else $error("limit-one rise not recorded");

   chk_irq_level: assert property (@(posedge clock)
      disable iff (!rst_n)
      (|(irq_stat_q & irq_mask_q)) |=> irq)
      else $error("interrupt low with an unmasked event");

   // Bus answer: one pulse per transfer, error only off the map
   chk_ready_pulse: assert property (@(posedge clock)
      disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready held for more than one cycle");

   chk_err_unmapped: assert property (@(posedge clock)
      disable iff (!rst_n)
      xfer_end |-> pslverr == !hit_any)
      else $error("error flag does not match the address decode");

   chk_cfg_write: assert property (@(posedge clock) // R5
      disable iff (!rst_n)
      wr_en && hit_cfg |=> cfg_q == ($past(pwdata) & CFG_MASK))
      else $error("configuration write did not land");

endmodule

/* File: tb/dcta_conv_model.sv */
`timescale 1ns/10ps
module dcta_conv_model
   import dcta_pkg::*;
(
   input  logic       clock,
   input  logic       rst_n,
   input  logic       conv_start,
   input  logic       conv_channel,
   input  dcta_temp_t temp0,
   input  dcta_temp_t temp1,
   output logic       conv_done,
   output dcta_temp_t conv_temp
);
   logic       busy_q;
   logic       slow_q;
   logic       ch_q;
   logic [2:0] cnt_q;

   // Replies alternate prompt and slow; idle data toggles every cycle so
   // that a stale value can never pass for a fresh reading
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_q    <= 1'b0;
         slow_q    <= 1'b0;
         ch_q      <= 1'b0;
         cnt_q     <= 3'h0;
         conv_done <= 1'b0;
         conv_temp <= 10'h2AA;
      end
      else
      begin
         conv_done <= 1'b0;
         conv_temp <= ~conv_temp;
         if (conv_start)
         begin
            busy_q <= 1'b1;
            ch_q   <= conv_channel;
            cnt_q  <= slow_q ? 3'h7 : 3'h1;
            slow_q <= ~slow_q;
         end
         else if (busy_q)
         begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1)
            begin
               busy_q    <= 1'b0;
               conv_done <= 1'b1;
               conv_temp <= ch_q ? temp1 : temp0;
            end
         end
      end
   end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`define CHECK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
      end \
   end
module tb_top
   import dcta_pkg::*;
;
   logic              clock;
   logic              rst_n;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              conv_start;
   logic              conv_channel;
   logic              conv_done;
   dcta_temp_t        conv_temp;
   dcta_temp_t        temp0;
   dcta_temp_t        temp1;
   logic [2:0]        oe;
   logic [2:0]        drv;
   tri1               critical_compare_pin;
   tri1               l0_pin;
   tri1               l1_pin;
   logic              irq;
   logic              exp_ch;
   logic [DATA_W-1:0] r;
   logic              e;
   int                err_count;
   int                comparisons;

   // Pull-ups stand on the board; the block only ever pulls low
   assign critical_compare_pin = oe[0] ? drv[0] : 1'bz;
   assign l0_pin   = oe[1] ? drv[1] : 1'bz;
   assign l1_pin   = oe[2] ? drv[2] : 1'bz;

   dcta_top dcta_top_inst (
      .clock               (clock),
      .rst_n               (rst_n),
      .psel                (psel),
      .penable             (penable),
      .pwrite              (pwrite),
      .paddr               (paddr),
      .pwdata              (pwdata),
      .prdata              (prdata),
      .pready              (pready),
      .pslverr             (pslverr),
      .conv_start          (conv_start),
      .conv_channel        (conv_channel),
      .conv_done           (conv_done),
      .conv_temp           (conv_temp),
      .critical_alarm_n_i  (critical_compare_pin),
      .critical_alarm_n_o  (drv[0]),
      .critical_alarm_n_oe (oe[0]),
      .limit0_alarm_n_i    (l0_pin),
      .limit0_alarm_n_o    (drv[1]),
      .limit0_alarm_n_oe   (oe[1]),
      .limit1_alarm_n_i    (l1_pin),
      .limit1_alarm_n_o    (drv[2]),
      .limit1_alarm_n_oe   (oe[2]),
      .irq                 (irq)
   );

   dcta_conv_model dcta_conv_model_inst (
      .clock        (clock),
      .rst_n        (rst_n),
      .conv_start   (conv_start),
      .conv_channel (conv_channel),
      .temp0        (temp0),
      .temp1        (temp1),
      .conv_done    (conv_done),
      .conv_temp    (conv_temp)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic summarize;
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_count++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] x,
                         input logic [DATA_W-1:0] m);
      apb(1'b0, a, 32'h0);
      `CHECK(r & m, x)
   endtask

   // Counts conversion answers; the scan is slow, so the bound is wide
   task automatic wait_done(input int k);
      int n;
      n = 0;
      while (k > 0 && n < 4000)
      begin
         @(negedge clock);
         n++;
         if (conv_done === 1'b1)
            k--;
      end
      if (k > 0)
      begin
         err_count++;
         summarize();
      end
   endtask

   // Pins as {limit1, limit0, critical}, seen a few cycles after a reading
   task automatic chk_pins(input logic [2:0] x);
      repeat (4) @(negedge clock);
      `CHECK({l1_pin, l0_pin, critical_compare_pin}, x)
      `CHECK(drv & oe, 3'h0)
      @(posedge clock);
   endtask

   // Two full scans so each channel converts twice with the new values
   task automatic step(input logic [DATA_W-1:0] cfg,
                       input dcta_temp_t t0, input dcta_temp_t t1,
                       input logic [2:0] x);
      apb(1'b1, REG_CONFIG, cfg);
      temp0 <= t0;
      temp1 <= t1;
      wait_done(4);
      chk_pins(x);
   endtask

   // Channels must alternate, starting with channel zero
   always @(negedge clock)
      if (rst_n && conv_start === 1'b1)
      begin
         `CHECK(conv_channel, exp_ch)
         exp_ch = ~exp_ch;
      end

   initial
   begin
      err_count = 0;
      comparisons = 0;
      exp_ch = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      temp0 = 10'h06E;
      temp1 = 10'h06E;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd_chk(REG_CONFIG, CFG_RESET, 32'hFFFFFFFF);
      rd_chk(REG_LIMITS, LIM_RESET, 32'hFFFFFFFF);
      rd_chk(REG_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
      wait_done(1);
      chk_pins(3'h7);
      wait_done(1);
      chk_pins(3'h0);
      rd_chk(REG_IRQ_STAT, 32'h7, 32'h7);
      `CHECK(irq, 1'b0)
      apb(1'b1, REG_IRQ_MASK, 32'h1);
      @(posedge clock);
      @(negedge clock);
      `CHECK(irq, 1'b1)
      @(posedge clock);
      apb(1'b1, REG_IRQ_STAT, 32'h1);
      @(posedge clock);
      @(negedge clock);
      `CHECK(irq, 1'b0)
      @(posedge clock);
      rd_chk(REG_IRQ_STAT, 32'h6, 32'h7);
      apb(1'b1, REG_IRQ_MASK, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      `CHECK({e, r}, 33'h100000000)
      // Critical 100, limit0 offset -1 gives 97, limit1 offset +1 gives 105
      apb(1'b1, REG_LIMITS, 32'h00013F64);
      rd_chk(REG_LIMITS, 32'h00013F64, 32'hFFFFFFFF);
      step(32'h1, 10'h032, 10'h032, 3'h7);
      step(32'h1, 10'h061, 10'h032, 3'h7);
      step(32'h1, 10'h062, 10'h032, 3'h5);
      step(32'h1, 10'h065, 10'h032, 3'h4);
      step(32'h1, 10'h064, 10'h032, 3'h4);
      step(32'h1, 10'h061, 10'h032, 3'h5);
      step(32'h1, 10'h060, 10'h032, 3'h7);
      step(32'h1, 10'h032, 10'h06A, 3'h2);
      step(32'h1, 10'h065, 10'h06A, 3'h0);
      rd_chk(REG_STATUS, 32'h0000007F, 32'hFFFFFFFF);
      step(32'h1, 10'h065, 10'h032, 3'h4);
      step(32'h1, 10'h032, 10'h032, 3'h7);
      step(32'hF, 10'h065, 10'h06E, 3'h7);
      step(32'hF, 10'h060, 10'h06E, 3'h4);
      rd_chk(REG_READING0, 32'h60, 32'hFFFFFFFF);
      step(32'hF, 10'h061, 10'h06E, 3'h4);
      step(32'hF, 10'h064, 10'h06E, 3'h6);
      step(32'hF, 10'h065, 10'h068, 3'h3);
      step(32'hF, 10'h065, 10'h069, 3'h3);
      step(32'hF, 10'h065, 10'h06A, 3'h7);
      step(32'h3, 10'h032, 10'h032, 3'h6);
      step(32'h9, 10'h032, 10'h032, 3'h3);
      step(32'h5, 10'h032, 10'h032, 3'h5);
      summarize();
   end
endmodule
